// file: logic/ecrc_regs.vh
// Constants of the read-side correction and error capture block.
// Assumes a 22-bit memory word: 16 data bits, then 6 check bits.
`ifndef ECRC_REGS_VH
`define ECRC_REGS_VH

// ============================================================
// Word layout
`define ECRC_DATA_W 16
`define ECRC_CHK_W 6
`define ECRC_WORD_W 22
`define ECRC_SYN_W 5
`define ECRC_BANK_W 4
`define ECRC_CAP_W 10

// ============================================================
// Field positions in the stored word
`define ECRC_DATA_LSB 0
`define ECRC_DATA_MSB 15
`define ECRC_CHK_LSB 16
`define ECRC_CHK_MSB 21

// ============================================================
// Field positions in the capture register
`define ECRC_CAP_SYN_LSB 0
`define ECRC_CAP_SYN_MSB 5
`define ECRC_CAP_BANK_LSB 6
`define ECRC_CAP_BANK_MSB 9

// ============================================================
// Data bits covered by check bits 16 to 20
`define ECRC_MASK_G0 16'h01ff
`define ECRC_MASK_G1 16'habaa
`define ECRC_MASK_G2 16'hcccc
`define ECRC_MASK_G3 16'hf0f0
`define ECRC_MASK_G4 16'hff01

// ============================================================
// Reset values
`define ECRC_RST_DATA 16'h0000
`define ECRC_RST_CAP 10'h03f
`define ECRC_RST_LAMPS 10'h000

`endif

// file: logic/ecrc_error_capture.v
// Error capture register and the ten indicator lamp drivers.
// Assumes the strobe, bank and syndrome come from logic on mclk.
`timescale 1ns/100ps
`include "ecrc_regs.vh"

module ecrc_error_capture (
	// Clock and control
	input wire mclk,
	input wire rst_n,
	input wire clk_en,
	// Capture source
	input wire capture_stb,
	input wire [3:0] capture_bank,
	input wire [5:0] capture_syndrome_n,
	// Lamp power
	input wire lamp_enable,
	// Lamps
	output reg bank_lamp_0,
	output reg bank_lamp_1,
	output reg bank_lamp_2,
	output reg bank_lamp_3,
	output reg bit_lamp_low_group,
	output reg bit_lamp_code_lsb,
	output reg bit_lamp_code_mid,
	output reg bit_lamp_code_msb,
	output reg bit_lamp_high_group,
	output reg bit_lamp_parity,
	// Captured contents
	output wire [9:0] capture_q_out
);

	reg [9:0] cap_q;
	reg [9:0] cap_d;
	wire [9:0] lit;

	assign capture_q_out = cap_q;

	// ============================================================
	// Capture register
	always @* begin
		cap_d = cap_q;
		if (capture_stb) begin
			cap_d = {capture_bank, capture_syndrome_n};
		end
	end

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cap_q <= `ECRC_RST_CAP;
		end else if (clk_en) begin
			cap_q <= cap_d;
		end
	end

	// ============================================================
	// Lamp drive
	// Bank bits light when one, syndrome bits light when zero
	assign lit = {cap_q[`ECRC_CAP_BANK_MSB:`ECRC_CAP_BANK_LSB],
		~cap_q[`ECRC_CAP_SYN_MSB:`ECRC_CAP_SYN_LSB]};

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			{bank_lamp_3, bank_lamp_2, bank_lamp_1, bank_lamp_0, bit_lamp_parity,
				bit_lamp_high_group, bit_lamp_code_msb, bit_lamp_code_mid, bit_lamp_code_lsb,
				bit_lamp_low_group} <= `ECRC_RST_LAMPS;
		end else if (clk_en) begin
			// Bank number in binary, lamp 0 least significant
			{bank_lamp_3, bank_lamp_2, bank_lamp_1, bank_lamp_0} <=
				lamp_enable ? lit[9:6] : 4'h0;
			// Mismatch pattern, not a bit number
			{bit_lamp_parity, bit_lamp_high_group, bit_lamp_code_msb} <=
				lamp_enable ? lit[5:3] : 3'h0;
			{bit_lamp_code_mid, bit_lamp_code_lsb, bit_lamp_low_group} <=
				lamp_enable ? lit[2:0] : 3'h0;
		end
	end

endmodule // ecrc_error_capture

// file: logic/ecrc_read_correct.v
// Read-side single-bit correction, uncorrectable flag and error capture.
// Assumes the read word, its valid and the address come from logic on mclk;
// the disable and lamp jumpers arrive as asynchronous pins.
`timescale 1ns/100ps
`include "ecrc_regs.vh"

module ecrc_read_correct (
	// Clock, reset, clock enable
	input wire mclk,
	input wire reset_n,
	input wire clk_en,
	// Read request from the memory array
	input wire rd_valid,
	input wire [21:0] rd_word,
	input wire [3:0] rd_bank,
	// Jumper pins
	input wire ecc_disable_n,
	input wire lamp_enable,
	// Read answer to the requester
	output reg out_valid,
	output reg [15:0] out_data,
	output reg uncorrectable_error,
	output reg overall_parity_error_n,
	output reg [5:0] syndrome_bits_n,
	// Error lamps
	output wire bank_lamp_0,
	output wire bank_lamp_1,
	output wire bank_lamp_2,
	output wire bank_lamp_3,
	output wire bit_lamp_parity,
	output wire bit_lamp_high_group,
	output wire bit_lamp_code_msb,
	output wire bit_lamp_code_mid,
	output wire bit_lamp_code_lsb,
	output wire bit_lamp_low_group
);

	// ============================================================
	// Syndrome code of one data bit, group 4 down to group 0
	function [4:0] ecrc_bit_code;
		input integer idx;
		reg [15:0] m0;
		reg [15:0] m1;
		reg [15:0] m2;
		reg [15:0] m3;
		reg [15:0] m4;
		begin
			m0 = `ECRC_MASK_G0;
			m1 = `ECRC_MASK_G1;
			m2 = `ECRC_MASK_G2;
			m3 = `ECRC_MASK_G3;
			m4 = `ECRC_MASK_G4;
			ecrc_bit_code = {m4[idx], m3[idx], m2[idx], m1[idx], m0[idx]};
		end
	endfunction

	// ============================================================
	// Reset release and pin synchronisers
	reg rst_s1_q;
	reg rst_s2_q;
	wire rst_n;
	reg [1:0] dis_sync_q;
	reg [1:0] lamp_sync_q;
	wire ecc_on;
	wire lamp_on;

	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end
	assign rst_n = rst_s2_q;

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			dis_sync_q <= 2'b11;
			lamp_sync_q <= 2'b00;
		end else if (clk_en) begin
			dis_sync_q <= {dis_sync_q[0], ecc_disable_n};
			lamp_sync_q <= {lamp_sync_q[0], lamp_enable};
		end
	end
	assign ecc_on = dis_sync_q[1];
	assign lamp_on = lamp_sync_q[1];

	// ============================================================
	// Error detection
	wire [15:0] data_in;
	wire [5:0] chk_in;
	wire [4:0] syn;
	wire parity_bad;
	wire parity_err;
	wire syn_nonzero;
	wire err_detect;
	wire uncorr;

	assign data_in = rd_word[`ECRC_DATA_MSB:`ECRC_DATA_LSB];
	assign chk_in = rd_word[`ECRC_CHK_MSB:`ECRC_CHK_LSB];

	// Each check bit is odd parity over its group; a mismatch is even parity
	assign syn[0] = ~^{data_in & `ECRC_MASK_G0, chk_in[0]};
	assign syn[1] = ~^{data_in & `ECRC_MASK_G1, chk_in[1]};
	assign syn[2] = ~^{data_in & `ECRC_MASK_G2, chk_in[2]};
	assign syn[3] = ~^{data_in & `ECRC_MASK_G3, chk_in[3]};
	assign syn[4] = ~^{data_in & `ECRC_MASK_G4, chk_in[4]};

	// Whole word must hold odd parity; any odd error count breaks it
	assign parity_bad = ~^rd_word;
	assign parity_err = parity_bad & ecc_on;
	assign syn_nonzero = |syn;
	assign err_detect = parity_bad | syn_nonzero;

	// Even error count, or any odd error count with correction off
	assign uncorr = (syn_nonzero & ~parity_err) | (parity_bad & ~ecc_on);

	// ============================================================
	// Correction gates
	wire [15:0] flip;
	wire [15:0] fixed;

	genvar gi;
	generate
		for (gi = 0; gi < 16; gi = gi + 1) begin : g_fix
			// Odd error counts still invert whatever bit the code names
			assign flip[gi] = parity_err & (syn == ecrc_bit_code(gi));
			assign fixed[gi] = data_in[gi] ^ flip[gi];
		end
	endgenerate

	// ============================================================
	// Answer register
	reg [15:0] out_data_d;
	reg uncorr_d;

	always @* begin
		out_data_d = out_data;
		uncorr_d = uncorrectable_error;
		if (rd_valid) begin
			out_data_d = fixed;
			uncorr_d = uncorr;
		end
	end

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			out_valid <= 1'b0;
			out_data <= `ECRC_RST_DATA;
			uncorrectable_error <= 1'b0;
			overall_parity_error_n <= 1'b1;
			syndrome_bits_n <= 6'h3f;
		end else if (clk_en) begin
			out_valid <= rd_valid;
			out_data <= out_data_d;
			uncorrectable_error <= uncorr_d;
			if (rd_valid) begin
				overall_parity_error_n <= ~parity_err;
				syndrome_bits_n <= ~{parity_err, syn};
			end
		end
	end

	// ============================================================
	// Error capture and lamps
	// Lamp order: parity, then check groups 4 down to 0

	ecrc_error_capture u_capture (
		.mclk(mclk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.capture_stb(rd_valid & err_detect),
		.capture_bank(rd_bank),
		.capture_syndrome_n(~{parity_err, syn}),
		.lamp_enable(lamp_on),
		.bank_lamp_0(bank_lamp_0),
		.bank_lamp_1(bank_lamp_1),
		.bank_lamp_2(bank_lamp_2),
		.bank_lamp_3(bank_lamp_3),
		.bit_lamp_low_group(bit_lamp_low_group),
		.bit_lamp_code_lsb(bit_lamp_code_lsb),
		.bit_lamp_code_mid(bit_lamp_code_mid),
		.bit_lamp_code_msb(bit_lamp_code_msb),
		.bit_lamp_high_group(bit_lamp_high_group),
		.bit_lamp_parity(bit_lamp_parity),
		.capture_q_out()
	);

endmodule // ecrc_read_correct

// file: dv/ecrc_read_correct_chk.sv
// Port checker for the read correction and error capture block.
// Assumes a bind onto ecrc_read_correct; one clock domain on mclk.
`timescale 1ns/100ps
module ecrc_read_correct_chk (
	// Inputs
	input wire mclk, reset_n, clk_en, rd_valid, ecc_disable_n, lamp_enable,
	input wire [21:0] rd_word,
	input wire [3:0] rd_bank,
	// Read answer
	input wire out_valid, uncorrectable_error, overall_parity_error_n,
	input wire [15:0] out_data,
	input wire [5:0] syndrome_bits_n,
	// Lamps
	input wire bank_lamp_0, bank_lamp_1, bank_lamp_2, bank_lamp_3, bit_lamp_parity,
	input wire bit_lamp_high_group, bit_lamp_code_msb, bit_lamp_code_mid, bit_lamp_code_lsb,
	input wire bit_lamp_low_group
);
	// ====
	// Properties
	wire [9:0] lamps = {bank_lamp_3, bank_lamp_2, bank_lamp_1, bank_lamp_0, bit_lamp_parity,
		bit_lamp_high_group, bit_lamp_code_msb, bit_lamp_code_mid, bit_lamp_code_lsb,
		bit_lamp_low_group};
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	property p_answer; rd_valid && clk_en ##1 clk_en |-> out_valid; endproperty
	a_answer: assert property (p_answer) else $error("read not answered");
	property p_keep;
		rd_valid && clk_en ##1 clk_en && overall_parity_error_n |-> out_data == $past(rd_word[15:0]);
	endproperty
	a_keep: assert property (p_keep) else $error("data changed without correction");
	property p_one; rd_valid && clk_en ##1 clk_en |-> $onehot0(out_data ^ $past(rd_word[15:0]));
	endproperty
	a_one: assert property (p_one) else $error("more than one bit inverted");
	property p_flag;
		out_valid && overall_parity_error_n && syndrome_bits_n[4:0] != 5'h1f |-> uncorrectable_error;
	endproperty
	a_flag: assert property (p_flag) else $error("double error not flagged");
	property p_single; out_valid && !overall_parity_error_n |-> !uncorrectable_error; endproperty
	a_single: assert property (p_single) else $error("corrected error flagged");
	property p_off; (!ecc_disable_n && clk_en) [*4] ##0 out_valid |-> overall_parity_error_n;
	endproperty
	a_off: assert property (p_off) else $error("parity error while disabled");
	property p_dark; (!lamp_enable && clk_en) [*4] |-> lamps == 10'h000; endproperty
	a_dark: assert property (p_dark) else $error("lamp lit while unpowered");
	property p_lamps;
		(lamp_enable && clk_en) [*4] ##1 (rd_valid && lamp_enable && clk_en)
		##1 (lamp_enable && clk_en && syndrome_bits_n != 6'h3f) ##1 (lamp_enable && clk_en)
		|-> lamps == {$past(rd_bank, 2), ~$past(syndrome_bits_n)};
	endproperty
	a_lamps: assert property (p_lamps) else $error("lamps differ from capture");
	property p_hold;
		(lamp_enable && clk_en) [*4] ##1 (out_valid && syndrome_bits_n == 6'h3f
		&& !uncorrectable_error && lamp_enable && clk_en) ##1 (lamp_enable && clk_en)
		|-> $stable(lamps);
	endproperty
	a_hold: assert property (p_hold) else $error("capture changed on clean read");
	c_fix: cover property (out_valid && !overall_parity_error_n);
	c_bad: cover property (out_valid && uncorrectable_error);
	c_off: cover property (!ecc_disable_n ##1 out_valid);
endmodule // ecrc_read_correct_chk

// file: dv/ecrc_requester.sv
// Requester model: issues memory reads and takes the answer.
// Assumes the block answers one enabled cycle after each read.
`timescale 1ns/100ps
module ecrc_requester (
	// Clock and answer
	input wire mclk, out_valid, uncorrectable_error,
	input wire [15:0] out_data,
	// Read request
	output reg rd_valid,
	output reg [21:0] rd_word,
	output reg [3:0] rd_bank
);
	// ====
	// Read task
	reg got_valid, got_flag;
	reg [15:0] got_data;
	initial begin
		rd_valid = 1'b0;
		rd_word = 22'h0;
		rd_bank = 4'h0;
	end
	task read(input [21:0] w, input [3:0] b);
		begin
			@(negedge mclk);
			rd_valid = 1'b1;
			rd_word = w;
			rd_bank = b;
			@(negedge mclk);
			got_valid = out_valid;
			got_flag = uncorrectable_error;
			got_data = out_data;
			rd_valid = 1'b0;
			rd_word = ~w;
		end
	endtask
endmodule // ecrc_requester

// file: dv/test_ecrc_read_correct.sv
// Testbench for the read correction and error capture block.
// Assumes ecrc_regs.vh on the include path; inputs change at falling edges.
`timescale 1ns/100ps
`include "ecrc_regs.vh"
module test_ecrc_read_correct;
	// ====
	// Signals and instances
	reg mclk, reset_n, clk_en, ecc_disable_n, lamp_enable;
	wire rd_valid, out_valid, uncorrectable_error, overall_parity_error_n;
	wire [21:0] rd_word;
	wire [3:0] rd_bank;
	wire [15:0] out_data;
	wire [5:0] syndrome_bits_n;
	wire [9:0] lamps;
	integer errors, cmp_count, cycles, i;
	reg [21:0] good;
	reg [4:0] code;
	ecrc_read_correct DUT (.mclk(mclk), .reset_n(reset_n), .clk_en(clk_en), .rd_valid(rd_valid),
		.rd_word(rd_word), .rd_bank(rd_bank), .ecc_disable_n(ecc_disable_n),
		.lamp_enable(lamp_enable), .out_valid(out_valid), .out_data(out_data),
		.uncorrectable_error(uncorrectable_error), .syndrome_bits_n(syndrome_bits_n),
		.overall_parity_error_n(overall_parity_error_n), .bank_lamp_0(lamps[6]),
		.bank_lamp_1(lamps[7]), .bank_lamp_2(lamps[8]), .bank_lamp_3(lamps[9]),
		.bit_lamp_parity(lamps[5]), .bit_lamp_high_group(lamps[4]), .bit_lamp_code_msb(lamps[3]),
		.bit_lamp_code_mid(lamps[2]), .bit_lamp_code_lsb(lamps[1]), .bit_lamp_low_group(lamps[0]));
	ecrc_requester req (.mclk(mclk), .out_valid(out_valid), .uncorrectable_error(uncorrectable_error),
		.out_data(out_data), .rd_valid(rd_valid), .rd_word(rd_word), .rd_bank(rd_bank));
	// ====
	// Helpers
	function [4:0] syn_of(input [21:0] e);
		syn_of = {^(e[15:0] & `ECRC_MASK_G4) ^ e[20], ^(e[15:0] & `ECRC_MASK_G3) ^ e[19],
			^(e[15:0] & `ECRC_MASK_G2) ^ e[18], ^(e[15:0] & `ECRC_MASK_G1) ^ e[17],
			^(e[15:0] & `ECRC_MASK_G0) ^ e[16]};
	endfunction
	function [21:0] encode(input [15:0] d);
		reg [4:0] c;
		begin
			c = ~syn_of({6'h00, d});
			encode = {~^{d, c}, c, d};
		end
	endfunction
	task check(input [15:0] seen, input [15:0] want);
		begin
			cmp_count = cmp_count + 1;
			if (seen !== want) begin
				errors = errors + 1;
				$display("ERROR at %0t: seen %h expected %h", $time, seen, want);
			end
		end
	endtask
	task probe(input [21:0] e, input [3:0] b, input [15:0] wd, input wf, input [5:0] ws,
		input [9:0] wl);
		begin
			req.read(good ^ e, b);
			check(req.got_valid, 1'b1);
			check(req.got_data, wd);
			check(req.got_flag, wf);
			check(syndrome_bits_n, ws);
			check(overall_parity_error_n, ws[5]);
			@(negedge mclk);
			check(lamps, wl);
		end
	endtask
	task complete_run;
		begin
			$display("Comparisons %0d, mismatches %0d", cmp_count, errors);
			if (errors == 0 && cmp_count > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	// ====
	// Clock, timeout and tests
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cycles = cycles + 1;
		if (cycles == 2000) begin
			errors = errors + 1;
			complete_run;
		end
	end
	initial begin
		errors = 0;
		cmp_count = 0;
		cycles = 0;
		reset_n = 1'b0;
		clk_en = 1'b1;
		ecc_disable_n = 1'b1;
		lamp_enable = 1'b1;
		repeat (16) @(negedge mclk);
		reset_n = 1'b1;
		repeat (6) @(negedge mclk);
		check(lamps, 10'h000);
		good = encode(16'ha5c3);
		for (i = 0; i < 22; i = i + 1) begin
			code = syn_of(22'h1 << i);
			probe(22'h1 << i, i[3:0], good[15:0], 1'b0, ~{1'b1, code}, {i[3:0], 1'b1, code});
		end
		code = syn_of(22'h201);
		probe(22'h201, 4'h9, good[15:0] ^ 16'h0201, 1'b1, {1'b1, ~code}, {4'h9, 1'b0, code});
		code = syn_of(22'h00f);
		probe(22'h00f, 4'h6, good[15:0] ^ 16'h000f, 1'b1, {1'b1, ~code}, {4'h6, 1'b0, code});
		probe(22'h0, 4'h3, good[15:0], 1'b0, 6'h3f, {4'h6, 1'b0, code});
		ecc_disable_n = 1'b0;
		repeat (4) @(negedge mclk);
		code = syn_of(22'h008);
		probe(22'h008, 4'h2, good[15:0] ^ 16'h0008, 1'b1, {1'b1, ~code}, {4'h2, 1'b0, code});
		ecc_disable_n = 1'b1;
		lamp_enable = 1'b0;
		repeat (4) @(negedge mclk);
		check(lamps, 10'h000);
		lamp_enable = 1'b1;
		repeat (4) @(negedge mclk);
		check(lamps, {4'h2, 1'b0, code});
		clk_en = 1'b0;
		req.read(good ^ 22'h000001, 4'h5);
		check(req.got_valid, 1'b0);
		check(req.got_data, good[15:0] ^ 16'h0008);
		@(negedge mclk);
		check(lamps, {4'h2, 1'b0, code});
		clk_en = 1'b1;
		complete_run;
	end
endmodule // test_ecrc_read_correct
bind ecrc_read_correct ecrc_read_correct_chk u_chk (.mclk, .reset_n, .clk_en, .rd_valid,
	.ecc_disable_n, .lamp_enable, .rd_word, .rd_bank, .out_valid, .uncorrectable_error,
	.overall_parity_error_n, .out_data, .syndrome_bits_n, .bank_lamp_0, .bank_lamp_1,
	.bank_lamp_2, .bank_lamp_3, .bit_lamp_parity, .bit_lamp_high_group, .bit_lamp_code_msb,
	.bit_lamp_code_mid, .bit_lamp_code_lsb, .bit_lamp_low_group);
